// ### core/lacc_consts.svh
// Offsets, field positions, reset values and timing counts of the charge phase controller
`ifndef LACC_CONSTS_SVH
`define LACC_CONSTS_SVH
`define LACC_OFF_CTRL 8'h00
`define LACC_OFF_ICHG 8'h04
`define LACC_OFF_VCHG 8'h08
`define LACC_OFF_ABS_DELTA 8'h0C
`define LACC_OFF_EQ_DELTA 8'h10
`define LACC_OFF_MAX_ABS 8'h14
`define LACC_OFF_MAX_EQ 8'h18
`define LACC_OFF_CX_THR 8'h1C
`define LACC_OFF_TREG_START 8'h20
`define LACC_OFF_TREG_END 8'h24
`define LACC_OFF_STATUS 8'h28
`define LACC_OFF_ALERT 8'h2C
`define LACC_OFF_APPLIED 8'h30
`define LACC_CTRL_SUSPEND 0
`define LACC_CTRL_EQ_REQ 1
`define LACC_CTRL_COMP_EN 2
`define LACC_CTRL_ALERT_EN 3
`define LACC_CTRL_ARM_LSB 4
`define LACC_ARM_VALUE 4'hA
`define LACC_RST_ICHG 5'h1F
`define LACC_RST_VCHG 6'h15
`define LACC_RST_ABS_DELTA 6'h15
`define LACC_RST_EQ_DELTA 6'h2A
`define LACC_RST_MAX_ABS 16'h2A30
`define LACC_RST_MAX_EQ 16'h0E10
`define LACC_RST_CX_THR 16'h0100
`define LACC_RST_TREG_START 16'h0078
`define LACC_RST_TREG_END 16'h007D
`define LACC_ICODE_MAX 5'h1F
`define LACC_EQ_LIMIT 7'h3F
`define LACC_THERM_COLD 16'h53BD
`define LACC_THERM_HOT 16'h0390
`define LACC_STEP_US 400
`define LACC_CLK_MHZ 100
`define LACC_STEP_CYCLES (`LACC_STEP_US * `LACC_CLK_MHZ)
`define LACC_SEC_CYCLES 100000000
`endif

// ### core/lacc_pkg.sv
// Types shared by the charge phase controller
package lacc_pkg;
    typedef enum logic [2:0] {
        LACC_ABSORB = 3'b001,
        LACC_CONT = 3'b010,
        LACC_EQUAL = 3'b100
    } lacc_phase_t;
endpackage : lacc_pkg

// ### core/lacc_ctrl.sv
// Lead-acid charge phase controller with APB register slave
`timescale 1ns/1ps
`default_nettype none
`include "lacc_consts.svh"
module lacc_ctrl #(
    parameter int STEP_CYCLES = `LACC_STEP_CYCLES,
    parameter int SEC_CYCLES = `LACC_SEC_CYCLES,
    parameter bit FIXED_SETTINGS = 1'b0,
    parameter logic [15:0] THERM_25C = 16'h2B00,
    parameter int COMP_SHIFT = 10
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] die_temp,
    input wire logic [15:0] thermistor_code,
    input wire logic [15:0] battery_current,
    input wire logic cv_reached,
    input wire logic input_above_battery,
    input wire logic input_above_hysteresis,
    input wire logic input_above_wake_level,
    input wire logic input_above_1v,
    input wire logic reference_biased,
    input wire logic missing_frequency_resistor,
    input wire logic internal_supply_good,
    input wire logic thermal_shutdown,
    input wire logic [1:0] cells0_strap,
    input wire logic [1:0] cells1_strap,
    output logic [4:0] icharge_code,
    output logic [6:0] vcharge_code,
    output logic [2:0] cell_multiplier,
    output logic charge_enable,
    output logic ship_mode
);
    // Two-flop synchronisers for every pin-side input
    logic [60:0] sync1;
    logic [60:0] sync2;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {die_temp, thermistor_code, battery_current, cv_reached,
                      input_above_battery, input_above_hysteresis, input_above_wake_level,
                      input_above_1v, reference_biased, missing_frequency_resistor,
                      internal_supply_good, thermal_shutdown, cells0_strap, cells1_strap};
            sync2 <= sync1;
        end
    end
    wire logic [15:0] s_die = sync2[60:45];
    wire logic [15:0] s_therm = sync2[44:29];
    wire logic [15:0] s_ibat = sync2[28:13];
    wire logic s_cv = sync2[12];
    wire logic s_above_bat = sync2[11];
    wire logic s_above_hyst = sync2[10];
    wire logic s_wake = sync2[9];
    wire logic s_above_1v = sync2[8];
    wire logic s_ref = sync2[7];
    wire logic s_missing_frequency_resistor = sync2[6];
    wire logic s_intvcc = sync2[5];
    wire logic s_tsd = sync2[4];
    wire logic [1:0] s_c0 = sync2[3:2];
    wire logic [1:0] s_c1 = sync2[1:0];

    function automatic logic [4:0] lacc_cap(input logic [15:0] t, input logic [15:0] lo,
                                            input logic [15:0] hi);
        logic [20:0] num;
        logic [15:0] span;
        num = '0;
        span = hi - lo;
        if (t <= lo) begin
            lacc_cap = `LACC_ICODE_MAX;
        end else if (t >= hi || span == 16'h0000) begin
            lacc_cap = 5'h00;
        end else begin
            num = 21'(t - lo) * 21'd31;
            lacc_cap = 5'd31 - 5'(num / 21'(span));
        end
    endfunction : lacc_cap

    function automatic logic [6:0] lacc_sat7(input logic signed [17:0] v);
        if (v < 0) begin
            lacc_sat7 = 7'h00;
        end else if (v > 18'sd127) begin
            lacc_sat7 = 7'h7F;
        end else begin
            lacc_sat7 = v[6:0];
        end
    endfunction : lacc_sat7

    // Settings
    logic sw_suspend;
    logic eq_req;
    logic comp_en;
    logic alert_en;
    logic [3:0] ship_arm;
    logic [4:0] ichg_set;
    logic [5:0] vchg_set;
    logic [5:0] abs_delta;
    logic [5:0] eq_delta;
    logic [15:0] max_abs;
    logic [15:0] max_eq;
    logic [15:0] cx_thr;
    logic [15:0] treg_start;
    logic [15:0] treg_end;
    logic thermal_alert;
    logic ship_restore;
    lacc_pkg::lacc_phase_t phase;
    logic eq_done;

    wire logic wr = psel && penable && pready && pwrite;
    wire logic wr_prog = wr && !FIXED_SETTINGS;

    // Cell strap decode: 0 ground, 1 mid rail, 2 logic supply
    logic [3:0] cell_count;
    logic cell_err;
    always_comb begin
        cell_err = 1'b0;
        case ({s_c1, s_c0})
            4'hA: cell_count = 4'h2;
            4'h9: cell_count = 4'h4;
            4'h8: cell_count = 4'h6;
            4'h6: cell_count = 4'h8;
            default: begin
                cell_count = 4'h0;
                cell_err = 1'b1;
            end
        endcase
    end

    // Software settings; a ship wake also restores every default
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sw_suspend <= 1'b0;
            comp_en <= 1'b1;
            alert_en <= 1'b0;
            ship_arm <= 4'h0;
            ichg_set <= `LACC_RST_ICHG;
            vchg_set <= `LACC_RST_VCHG;
            abs_delta <= `LACC_RST_ABS_DELTA;
            eq_delta <= `LACC_RST_EQ_DELTA;
            max_abs <= `LACC_RST_MAX_ABS;
            max_eq <= `LACC_RST_MAX_EQ;
            cx_thr <= `LACC_RST_CX_THR;
            treg_start <= `LACC_RST_TREG_START;
            treg_end <= `LACC_RST_TREG_END;
        end else if (ship_restore) begin
            sw_suspend <= 1'b0;
            comp_en <= 1'b1;
            alert_en <= 1'b0;
            ship_arm <= 4'h0;
            ichg_set <= `LACC_RST_ICHG;
            vchg_set <= `LACC_RST_VCHG;
            abs_delta <= `LACC_RST_ABS_DELTA;
            eq_delta <= `LACC_RST_EQ_DELTA;
            max_abs <= `LACC_RST_MAX_ABS;
            max_eq <= `LACC_RST_MAX_EQ;
            cx_thr <= `LACC_RST_CX_THR;
            treg_start <= `LACC_RST_TREG_START;
            treg_end <= `LACC_RST_TREG_END;
        end else if (wr) begin
            case (paddr)
                `LACC_OFF_CTRL: begin
                    sw_suspend <= pwdata[`LACC_CTRL_SUSPEND];
                    alert_en <= pwdata[`LACC_CTRL_ALERT_EN];
                    ship_arm <= pwdata[`LACC_CTRL_ARM_LSB +: 4];
                    if (!FIXED_SETTINGS) begin
                        comp_en <= pwdata[`LACC_CTRL_COMP_EN];
                    end
                end
                `LACC_OFF_ICHG: ichg_set <= pwdata[4:0];
                `LACC_OFF_VCHG: if (wr_prog) vchg_set <= pwdata[5:0];
                `LACC_OFF_ABS_DELTA: if (wr_prog) abs_delta <= pwdata[5:0];
                `LACC_OFF_EQ_DELTA: if (wr_prog) eq_delta <= pwdata[5:0];
                `LACC_OFF_MAX_ABS: if (wr_prog) max_abs <= pwdata[15:0];
                `LACC_OFF_MAX_EQ: if (wr_prog) max_eq <= pwdata[15:0];
                `LACC_OFF_CX_THR: cx_thr <= pwdata[15:0];
                `LACC_OFF_TREG_START: treg_start <= pwdata[15:0];
                `LACC_OFF_TREG_END: treg_end <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Equalize request: hardware clear on phase end, software may set
    wire logic eq_wr = wr && paddr == `LACC_OFF_CTRL;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            eq_req <= 1'b0;
        end else if (ship_restore) begin
            eq_req <= 1'b0;
        end else if (eq_wr) begin
            eq_req <= pwdata[`LACC_CTRL_EQ_REQ];
        end else if (eq_done) begin
            eq_req <= 1'b0;
        end
    end

    // Thermal regulation
    wire logic [4:0] therm_cap = lacc_cap(s_die, treg_start, treg_end);
    wire logic therm_active = therm_cap < `LACC_ICODE_MAX;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            thermal_alert <= 1'b0;
        end else if (ship_restore || !alert_en) begin
            thermal_alert <= 1'b0;
        end else if (therm_active) begin
            thermal_alert <= 1'b1;
        end else if (wr && paddr == `LACC_OFF_ALERT && !pwdata[0]) begin
            thermal_alert <= 1'b0;
        end
    end

    // Suspend and re-enable
    wire logic fault = sw_suspend || !s_above_bat || s_tsd || s_missing_frequency_resistor || !s_intvcc
                       || !s_wake || cell_err;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            charge_enable <= 1'b0;
        end else if (fault) begin
            charge_enable <= 1'b0;
        end else if (s_above_hyst) begin
            charge_enable <= 1'b1;
        end
    end

    // Second tick for phase timers
    logic [31:0] sec_cnt;
    wire logic sec_tick = sec_cnt == 32'(SEC_CYCLES - 1);
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sec_cnt <= '0;
        end else begin
            sec_cnt <= sec_tick ? '0 : sec_cnt + 32'h1;
        end
    end

    // Charge phases
    logic [15:0] phase_timer;
    assign eq_done = phase == lacc_pkg::LACC_EQUAL && phase_timer >= max_eq;
    wire logic abs_done = phase_timer >= max_abs || s_ibat < cx_thr;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase <= lacc_pkg::LACC_ABSORB;
            phase_timer <= '0;
        end else if (!charge_enable || ship_restore) begin
            phase <= lacc_pkg::LACC_ABSORB;
            phase_timer <= '0;
        end else begin
            case (phase)
                lacc_pkg::LACC_ABSORB: begin
                    if (abs_done) begin
                        phase <= lacc_pkg::LACC_CONT;
                        phase_timer <= '0;
                    end else if (s_cv && sec_tick) begin
                        phase_timer <= phase_timer + 16'h1;
                    end
                end
                lacc_pkg::LACC_CONT: begin
                    if (eq_req) begin
                        phase <= lacc_pkg::LACC_EQUAL;
                    end
                    phase_timer <= '0;
                end
                lacc_pkg::LACC_EQUAL: begin
                    if (eq_done) begin
                        phase <= lacc_pkg::LACC_CONT;
                        phase_timer <= '0;
                    end else if (sec_tick) begin
                        phase_timer <= phase_timer + 16'h1;
                    end
                end
                default: phase <= lacc_pkg::LACC_ABSORB;
            endcase
        end
    end

    // Voltage target; per-6V code, 28.571mV per step
    logic [6:0] base_code;
    logic signed [17:0] comp_ofs;
    always_comb begin
        case (phase)
            lacc_pkg::LACC_ABSORB: base_code = {1'b0, vchg_set} + {1'b0, abs_delta};
            lacc_pkg::LACC_EQUAL: begin
                base_code = {1'b0, vchg_set} + {1'b0, eq_delta};
                if (base_code > `LACC_EQ_LIMIT) base_code = `LACC_EQ_LIMIT;
            end
            default: base_code = {1'b0, vchg_set};
        endcase
        comp_ofs = 18'sd0;
        // Straight-line slope; thermistor curve error is accepted
        if (comp_en && s_therm < `LACC_THERM_COLD && s_therm > `LACC_THERM_HOT) begin
            comp_ofs = 18'(($signed({2'b00, s_therm}) - $signed({2'b00, THERM_25C}))
                       >>> COMP_SHIFT);
        end
    end

    // Current ramp, one code per step interval
    logic [31:0] step_cnt;
    wire logic [4:0] i_target = ichg_set < therm_cap ? ichg_set : therm_cap;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            step_cnt <= '0;
            icharge_code <= 5'h00;
        end else if (!charge_enable) begin
            step_cnt <= '0;
            icharge_code <= 5'h00;
        end else if (step_cnt >= 32'(STEP_CYCLES - 1)) begin
            step_cnt <= '0;
            if (icharge_code < i_target) icharge_code <= icharge_code + 5'h1;
            else if (icharge_code > i_target) icharge_code <= icharge_code - 5'h1;
        end else begin
            step_cnt <= step_cnt + 32'h1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            vcharge_code <= 7'h00;
            cell_multiplier <= 3'h0;
        end else begin
            vcharge_code <= lacc_sat7(18'(base_code) + comp_ofs);
            cell_multiplier <= cell_count[3:1];
        end
    end

    // Ship mode: enter when armed and input gone, wake restores defaults
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ship_mode <= 1'b0;
            ship_restore <= 1'b0;
        end else begin
            ship_restore <= 1'b0;
            if (!ship_mode && ship_arm == `LACC_ARM_VALUE && !s_above_1v) begin
                ship_mode <= 1'b1;
            end else if (ship_mode && s_above_1v && s_ref && s_wake) begin
                ship_mode <= 1'b0;
                ship_restore <= 1'b1;
            end
        end
    end

    // APB slave, one wait state so read data comes from a flop
    logic [31:0] rd_mux;
    logic rd_bad;
    always_comb begin
        rd_bad = 1'b0;
        case (paddr)
            `LACC_OFF_CTRL: rd_mux = {24'h0, ship_arm, alert_en, comp_en, eq_req, sw_suspend};
            `LACC_OFF_ICHG: rd_mux = {27'h0, ichg_set};
            `LACC_OFF_VCHG: rd_mux = {26'h0, vchg_set};
            `LACC_OFF_ABS_DELTA: rd_mux = {26'h0, abs_delta};
            `LACC_OFF_EQ_DELTA: rd_mux = {26'h0, eq_delta};
            `LACC_OFF_MAX_ABS: rd_mux = {16'h0, max_abs};
            `LACC_OFF_MAX_EQ: rd_mux = {16'h0, max_eq};
            `LACC_OFF_CX_THR: rd_mux = {16'h0, cx_thr};
            `LACC_OFF_TREG_START: rd_mux = {16'h0, treg_start};
            `LACC_OFF_TREG_END: rd_mux = {16'h0, treg_end};
            `LACC_OFF_STATUS: rd_mux = {21'h0, cell_count, cell_err, phase, ship_mode,
                                        !charge_enable, therm_active};
            `LACC_OFF_ALERT: rd_mux = {31'h0, thermal_alert};
            `LACC_OFF_APPLIED: rd_mux = {20'h0, vcharge_code, icharge_code};
            default: begin
                rd_mux = 32'h0;
                rd_bad = 1'b1;
            end
        endcase
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && rd_bad;
            if (psel && penable && !pready && !pwrite) prdata <= rd_mux;
        end
    end

    property p_cap_zero;
        @(posedge core_clk) disable iff (!reset_n)
        (s_die >= treg_end && treg_end > treg_start) |-> therm_cap == 5'h00;
    endproperty
    a_cap_zero: assert property (p_cap_zero) else $error("cap not zero at end temp");
    // Cycles spent above target without a downward step
    logic [31:0] down_wait;
    logic [4:0] icode_prev;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            down_wait <= '0;
            icode_prev <= 5'h00;
        end else begin
            icode_prev <= icharge_code;
            if (!charge_enable || icharge_code <= i_target || icharge_code < icode_prev) begin
                down_wait <= '0;
            end else begin
                down_wait <= down_wait + 32'h1;
            end
        end
    end
    property p_cap_bound;
        @(posedge core_clk) disable iff (!reset_n)
        down_wait <= 32'(STEP_CYCLES);
    endproperty
    a_cap_bound: assert property (p_cap_bound) else $error("current not lowered");
    property p_alert;
        @(posedge core_clk) disable iff (!reset_n)
        alert_en && therm_active && !ship_restore |=> thermal_alert;
    endproperty
    a_alert: assert property (p_alert) else $error("thermal alert not latched");
    property p_suspend;
        @(posedge core_clk) disable iff (!reset_n)
        fault |=> !charge_enable;
    endproperty
    a_suspend: assert property (p_suspend) else $error("charging not suspended");
    property p_reenable;
        @(posedge core_clk) disable iff (!reset_n)
        !charge_enable && !s_above_hyst |=> !charge_enable;
    endproperty
    a_reenable: assert property (p_reenable) else $error("enabled without hysteresis");
    property p_abs_start;
        @(posedge core_clk) disable iff (!reset_n)
        $rose(charge_enable) |-> phase == lacc_pkg::LACC_ABSORB && phase_timer == 16'h0;
    endproperty
    a_abs_start: assert property (p_abs_start) else $error("cycle not in absorb");
    property p_abs_hold;
        @(posedge core_clk) disable iff (!reset_n)
        phase == lacc_pkg::LACC_ABSORB && !s_cv && !abs_done && charge_enable
        |=> $stable(phase_timer);
    endproperty
    a_abs_hold: assert property (p_abs_hold) else $error("absorb timer ran in CC");
    property p_eq_end;
        @(posedge core_clk) disable iff (!reset_n)
        eq_done && charge_enable && !ship_restore
        |=> phase == lacc_pkg::LACC_CONT && (!eq_req || $past(eq_wr));
    endproperty
    a_eq_end: assert property (p_eq_end) else $error("equalize end wrong");
    property p_eq_clamp;
        @(posedge core_clk) disable iff (!reset_n)
        phase == lacc_pkg::LACC_EQUAL |-> base_code <= `LACC_EQ_LIMIT;
    endproperty
    a_eq_clamp: assert property (p_eq_clamp) else $error("equalize above limit");
    property p_ship;
        @(posedge core_clk) disable iff (!reset_n)
        $rose(ship_mode) |-> $past(ship_arm) == `LACC_ARM_VALUE && !$past(s_above_1v);
    endproperty
    a_ship: assert property (p_ship) else $error("ship mode without arm");
endmodule : lacc_ctrl
`default_nettype wire

// ### tb/lacc_stage_model.sv
// Power stage and telemetry stand-in for the charge phase controller
`timescale 1ns/1ps
`default_nettype none
module lacc_stage_model #(
    parameter int CV_DLY = 8
) (
    input wire logic core_clk,
    input wire logic vin_ok,
    input wire logic [15:0] die_c,
    input wire logic [15:0] therm_c,
    input wire logic charge_enable,
    output logic [15:0] die_temp,
    output logic [15:0] thermistor_code,
    output logic [15:0] battery_current,
    output logic cv_reached,
    output logic input_above_battery,
    output logic input_above_hysteresis,
    output logic input_above_wake_level,
    output logic input_above_1v,
    output logic reference_biased,
    output logic thermal_shutdown
);
    int cnt;
    // Current mode first, so the absorb timer must wait
    always_ff @(posedge core_clk) begin
        if (!charge_enable) begin
            cnt <= 0;
        end else if (cnt < CV_DLY) begin
            cnt <= cnt + 1;
        end
    end
    assign cv_reached = charge_enable && (cnt == CV_DLY);
    // Kept above the reset threshold so only the timer ends absorb
    assign battery_current = cv_reached ? 16'h0200 : 16'h0400;
    assign die_temp = die_c;
    // Bench steers the thermistor to exercise compensation
    assign thermistor_code = therm_c;
    assign thermal_shutdown = die_c > 16'h0096;
    assign input_above_battery = vin_ok;
    assign input_above_hysteresis = vin_ok;
    assign input_above_wake_level = vin_ok;
    assign input_above_1v = vin_ok;
    assign reference_biased = vin_ok;
endmodule : lacc_stage_model
`default_nettype wire

// ### tb/tb_lead_acid_charge_phase_controller.sv
// Self-checking bench for the charge phase controller
`timescale 1ns/1ps
`default_nettype none
module tb_lead_acid_charge_phase_controller;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic vin_ok = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] die_c = 16'h0019;
    logic [15:0] therm_c = 16'h2B00;
    logic missing_frequency_resistor = 1'b0;
    logic internal_supply_good = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, cv_reached, input_above_battery, input_above_hysteresis;
    logic input_above_wake_level, input_above_1v, reference_biased, thermal_shutdown;
    logic [15:0] die_temp, thermistor_code, battery_current;
    logic [4:0] icharge_code;
    logic [6:0] vcharge_code, eqv;
    logic [2:0] cell_multiplier;
    logic charge_enable, ship_mode;
    logic [5:0] v;
    logic [31:0] rv[7] = '{32'h4, 32'h1F, 32'h15, 32'h15, 32'h2A, 32'h2A30, 32'h0E10};
    logic [64:0] q[$];
    logic [64:0] e;
    int error_cnt = 0;
    int n_compared = 0;

    lacc_ctrl #(.STEP_CYCLES(4), .SEC_CYCLES(10)) i_lacc_ctrl (.core_clk, .reset_n, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .die_temp,
        .thermistor_code, .battery_current, .cv_reached, .input_above_battery,
        .input_above_hysteresis, .input_above_wake_level, .input_above_1v, .reference_biased,
        .missing_frequency_resistor, .internal_supply_good, .thermal_shutdown,
        .cells0_strap(2'h1), .cells1_strap(2'h2), .icharge_code, .vcharge_code,
        .cell_multiplier, .charge_enable, .ship_mode);
    lacc_stage_model i_lacc_stage_model (.core_clk, .vin_ok, .die_c, .therm_c, .charge_enable,
        .die_temp, .thermistor_code, .battery_current, .cv_reached, .input_above_battery,
        .input_above_hysteresis, .input_above_wake_level, .input_above_1v,
        .reference_biased, .thermal_shutdown);

    always #5 core_clk = ~core_clk;

    task automatic print_verdict();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
        n_compared++;
        if (x !== got) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, x, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk("pready", 32'h1, {31'h0, pready});
            print_verdict();
        end
        @(posedge core_clk);
    endtask : apb

    // Note first, so the watcher never finds the queue empty
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                      input logic er);
        q.push_back({m, er, x});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic wait_on(input logic [1:0] sel, input logic [6:0] x);
        logic [6:0] got;
        int k;
        for (k = 0; k < 600; k++) begin
            @(posedge core_clk);
            got = (sel == 2'h0) ? vcharge_code : (sel == 2'h1) ? {2'h0, icharge_code} :
                  {6'h0, ship_mode};
            if (got === x) break;
        end
        chk("output level", {25'h0, x}, {25'h0, got});
        if (k == 600) print_verdict();
    endtask : wait_on

    always @(posedge core_clk) begin
        if (psel && penable && pready && !pwrite) begin
            e = q.pop_front();
            chk("prdata", e[31:0], prdata & e[64:33]);
            chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
        end
    end

    initial begin
        void'($urandom(32'h3023));
        v = 6'($urandom_range(30, 0));
        eqv = ({1'b0, v} + 7'h2A > 7'h3F) ? 7'h3F : {1'b0, v} + 7'h2A;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        foreach (rv[i]) rd(8'(4 * i), 32'hFFFFFFFF, rv[i], 1'b0);
        rd(8'h3C, 32'hFFFFFFFF, 32'h0, 1'b1);
        apb(1'b1, 8'h3C, 32'h7);
        apb(1'b1, 8'h14, 32'h3);
        apb(1'b1, 8'h18, 32'h2);
        apb(1'b1, 8'h08, {26'h0, v});
        chk("cell_multiplier", 32'h2, {29'h0, cell_multiplier});
        vin_ok <= 1'b1;
        wait_on(2'h0, {1'b0, v} + 7'h15);
        rd(8'h28, 32'h38, 32'h08, 1'b0);
        wait_on(2'h0, {1'b0, v});
        rd(8'h28, 32'h38, 32'h10, 1'b0);
        apb(1'b1, 8'h00, 32'h6);
        wait_on(2'h0, eqv);
        rd(8'h28, 32'h38, 32'h20, 1'b0);
        wait_on(2'h0, {1'b0, v});
        rd(8'h00, 32'hFF, 32'h4, 1'b0);
        therm_c <= 16'h3300;
        wait_on(2'h0, {1'b0, v} + 7'h02);
        therm_c <= 16'h5400;
        wait_on(2'h0, {1'b0, v});
        therm_c <= 16'h2B00;
        die_c <= 16'h007D;
        wait_on(2'h1, 7'h0);
        apb(1'b1, 8'h00, 32'hC);
        rd(8'h28, 32'h1, 32'h1, 1'b0);
        rd(8'h2C, 32'h1, 32'h1, 1'b0);
        die_c <= 16'h0019;
        // Set wins over the clear, so let the cap lift first
        repeat (4) @(posedge core_clk);
        apb(1'b1, 8'h2C, 32'h0);
        rd(8'h2C, 32'h1, 32'h0, 1'b0);
        wait_on(2'h1, 7'h1F);
        apb(1'b1, 8'h00, 32'h5);
        rd(8'h28, 32'h2, 32'h2, 1'b0);
        chk("charge_enable", 32'h0, {31'h0, charge_enable});
        apb(1'b1, 8'h00, 32'h4);
        wait_on(2'h0, {1'b0, v} + 7'h15);
        apb(1'b1, 8'h14, 32'hFFFF);
        apb(1'b1, 8'h1C, 32'h300);
        wait_on(2'h0, {1'b0, v});
        missing_frequency_resistor <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(8'h28, 32'h2, 32'h2, 1'b0);
        missing_frequency_resistor <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk("charge_enable", 32'h1, {31'h0, charge_enable});
        internal_supply_good <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk("charge_enable", 32'h0, {31'h0, charge_enable});
        internal_supply_good <= 1'b1;
        apb(1'b1, 8'h00, 32'hA4);
        apb(1'b1, 8'h08, 32'h3);
        vin_ok <= 1'b0;
        wait_on(2'h2, 7'h1);
        vin_ok <= 1'b1;
        wait_on(2'h2, 7'h0);
        repeat (2) @(posedge core_clk);
        rd(8'h08, 32'hFF, 32'h15, 1'b0);
        rd(8'h00, 32'hFF, 32'h4, 1'b0);
        print_verdict();
    end
endmodule : tb_lead_acid_charge_phase_controller
`default_nettype wire
